// file: shared/flash_host_pkg.sv
// package: constants and carrier types for the sector flash host controller
package flash_host_pkg;
  localparam int ADDR_W           = 19;
  localparam int DATA_W           = 8;
  localparam int SECTOR_COUNT     = 2048;
  localparam int SECTOR_BYTES     = 256;
  localparam int BYTE_ADDR_W      = 8;
  localparam int BOOT_BLOCK_BYTES = 16384;
  localparam int CLK_MHZ          = 40;
  // timing figures as printed, in their own units
  localparam int LOAD_GAP_US      = 150;
  localparam int POWER_UP_MS      = 10;
  localparam int PROGRAM_MAX_MS   = 20;
  localparam int STROBE_MIN_NS    = 15;
  localparam int CLK_PERIOD_NS    = 25;
  // longest gap rounds down, least times round up
  localparam int LOAD_GAP_CYC     = LOAD_GAP_US * CLK_MHZ;
  localparam int POWER_UP_CYC     = POWER_UP_MS * 1000 * CLK_MHZ;
  localparam int PROGRAM_MAX_CYC  = PROGRAM_MAX_MS * 1000 * CLK_MHZ;
  localparam int STROBE_CYC       =
    (STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACCESS_CYC       = 8;
  // lock-state read locations and values in identification mode
  localparam logic [18:0] LOCK_LO_ADDR = 19'h00002;
  localparam logic [18:0] LOCK_HI_ADDR = 19'h7fff2;
  localparam logic [7:0]  LOCK_FREE    = 8'hfe;
  localparam logic [7:0]  LOCK_SET     = 8'hff;
  localparam int POLL_BIT   = 7;
  localparam int TOGGLE_BIT = 6;

  typedef enum logic [2:0] {
    OP_READ   = 3'h0,
    OP_SECTOR = 3'h1,
    OP_CHIP   = 3'h2,
    OP_LOCK   = 3'h3,
    OP_ID_IN  = 3'h4,
    OP_ID_OUT = 3'h5
  } op_t;

  typedef struct packed {
    logic [18:0] addr;
    logic [7:0]  data;
  } cmd_word_t;

  typedef struct packed {
    logic        ceN;
    logic        oeN;
    logic        weN;
    logic [18:0] addr;
    logic [7:0]  dout;
    logic        doutEn;
  } pins_t;
endpackage : flash_host_pkg

// file: design/strobe_cycle.sv
// single bus cycle engine: one read or one write strobe on the flash pins
`timescale 1ns/10ps
module strobe_cycle
  import flash_host_pkg::*;
#(
  parameter int LOW_CYC = ACCESS_CYC
) (
  input  wire logic                   clk,
  input  wire logic                   arst_n,
  input  wire logic                   start,
  input  wire logic                   isWrite,
  input  wire flash_host_pkg::cmd_word_t word,
  input  wire logic [7:0]             pinData,
  output flash_host_pkg::pins_t       pins,
  output logic                        done,
  output logic [7:0]                  rdData
);
  import flash_host_pkg::*;

  typedef enum logic [1:0] {
    CY_IDLE = 2'b00,
    CY_LOW  = 2'b01,
    CY_HIGH = 2'b11
  } cy_t;

  cy_t         st_q, st_d;
  logic [7:0]  cnt_q, cnt_d;
  pins_t       pins_q, pins_d;
  logic        done_q, done_d;
  logic [7:0]  rd_q, rd_d;

  always_comb begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    pins_d = pins_q;
    done_d = 1'b0;
    rd_d   = rd_q;
    case (st_q)
      CY_IDLE: begin
        if (start) begin
          pins_d.addr   = word.addr;
          pins_d.dout   = word.data;
          // [RULE_09] byte load pulse
          pins_d.ceN    = 1'b0;
          pins_d.weN    = ~isWrite;
          pins_d.oeN    = isWrite;
          pins_d.doutEn = isWrite;
          cnt_d = 8'h00;
          st_d  = CY_LOW;
        end
      end
      CY_LOW: begin
        cnt_d = cnt_q + 8'h01;
        // [RULE_14] strobe wide enough
        if (cnt_q >= 8'(LOW_CYC - 1)) begin
          rd_d       = pinData;
          pins_d.ceN = 1'b1;
          pins_d.weN = 1'b1;
          pins_d.oeN = 1'b1;
          st_d       = CY_HIGH;
        end
      end
      CY_HIGH: begin
        pins_d.doutEn = 1'b0;
        done_d = 1'b1;
        st_d   = CY_IDLE;
      end
      default: st_d = CY_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q   <= CY_IDLE;
      cnt_q  <= 8'h00;
      pins_q <= '{ceN: 1'b1, oeN: 1'b1, weN: 1'b1, addr: '0,
                  dout: '0, doutEn: 1'b0};
      done_q <= 1'b0;
      rd_q   <= 8'h00;
    end else begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      pins_q <= pins_d;
      done_q <= done_d;
      rd_q   <= rd_d;
    end
  end

  assign pins   = pins_q;
  assign done   = done_q;
  assign rdData = rd_q;
endmodule : strobe_cycle

// file: design/sector_flash_host.sv
// host controller that reads, loads and programs the sector flash
`timescale 1ns/10ps
// Overview of operation
// [RULE_01] reads drive chip select and output enable low, write enable high
// [RULE_02] host drives data lines only during its own write strobes; code keeps flashDataOe high one cycle after flashWeN rises
// [RULE_03] programming works on whole 256-byte sectors of 2048 after unlock
// [RULE_04] host loads all 256 bytes of every programmed sector
// [RULE_05] device erases sector itself; host sends no erase
// [RULE_06] three unlock writes precede every sector program
// [RULE_07] protection persists over power; host always unlocks
// [RULE_08] writes without unlock store nothing and start the write timer
// [RULE_09] byte load is low strobe pulse with output enable high
// [RULE_10] next falling edge within 150 us, then host stops to let program
// [RULE_11] sector address held on upper lines for every byte
// [RULE_12] bytes may be loaded in any order
// [RULE_13] program cycles need output enable high and both strobes low
// [RULE_14] strobes last well over 15 ns
// [RULE_15] host waits 10 ms after power before programming
// [RULE_16] completion seen when bit 7 of last byte reads true
// [RULE_17] completion also seen when bit 6 stops toggling; for sector programs code needs bit 7 to match as well
// [RULE_18] program cycle ends within 20 ms, else timeout reported
// [RULE_19] chip erase issued as a six-write command code
// [RULE_20] boot blocks may be locked independently
// [RULE_21] boot block lockout issued as seven command writes
// [RULE_22] chip erase is pointless when a boot block is locked
// [RULE_23] id mode lock reads at 00002 and 7fff2, fe free, ff locked
// [RULE_24] id mode entered by software command sequence
// [RULE_25] command words are parameters supplied from outside
// [RULE_26] no new access until completion is seen
module sector_flash_host
  import flash_host_pkg::*;
#(
  parameter int POWER_CYC   = POWER_UP_CYC,
  parameter int PROG_CYC    = PROGRAM_MAX_CYC,
  parameter int GAP_CYC     = LOAD_GAP_CYC,
  parameter int SEQ_MAX     = 7
) (
  input  wire logic                   clk,
  input  wire logic                   arst_n,
  input  wire logic                   opValid,
  input  wire flash_host_pkg::op_t    opCode,
  input  wire logic [18:0]            opAddr,
  input  wire logic [2:0]             seqLen,
  input  wire flash_host_pkg::cmd_word_t seqWord,
  input  wire logic [7:0]             loadData,
  input  wire logic [7:0]             flashDataIn,
  output logic                        opReady,
  output logic [2:0]                  seqIndex,
  output logic [7:0]                  loadIndex,
  output logic                        rdValid,
  output logic [7:0]                  rdData,
  output logic                        opDone,
  output logic                        opTimeout,
  output logic                        flashCeN,
  output logic                        flashOeN,
  output logic                        flashWeN,
  output logic [18:0]                 address_lines,
  output logic [7:0]                  flashDataOut,
  output logic                        flashDataOe
);
  import flash_host_pkg::*;

  typedef enum logic [2:0] {
    S_POWER = 3'b000,
    S_IDLE  = 3'b001,
    S_CMD   = 3'b011,
    S_LOAD  = 3'b010,
    S_GAP   = 3'b110,
    S_POLL  = 3'b111,
    S_READ  = 3'b101
  } st_t;

  st_t        st_q, st_d;
  op_t        op_q, op_d;
  logic [18:0] addr_q, addr_d;
  logic [2:0] seq_q, seq_d;
  logic [8:0] byte_q, byte_d;
  logic [31:0] tmr_q, tmr_d;
  logic [7:0] last_q, last_d;
  logic       pollSeen_q, pollSeen_d, prev_q, prev_d;
  logic       rdv_q, rdv_d, done_q, done_d, tmo_q, tmo_d, rdy_q, rdy_d;
  logic [7:0] rdd_q, rdd_d;
  logic [7:0] lastByte_q, lastByte_d;
  logic       cyStart;
  logic       cyWrite;
  cmd_word_t  cyWord;
  pins_t      cyPins;
  logic       cyDone;
  logic [7:0] cyRd;
  logic [7:0] din1_q, din2_q, din3_q, dinOk_q, dinOk_d;

  // flash data pins cross in from outside the clock domain
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      din1_q <= 8'h00;
      din2_q <= 8'h00;
      din3_q <= 8'h00;
      dinOk_q <= 8'h00;
    end else begin
      din1_q <= flashDataIn;
      din2_q <= din1_q;
      din3_q <= din2_q;
      dinOk_q <= dinOk_d;
    end
  end

  // take a new value once the last two stages agree
  assign dinOk_d = (din2_q == din3_q) ? din3_q : dinOk_q;

  strobe_cycle #(.LOW_CYC(ACCESS_CYC)) u_cycle (
    .clk     (clk),
    .arst_n  (arst_n),
    .start   (cyStart),
    .isWrite (cyWrite),
    .word    (cyWord),
    .pinData (dinOk_q),
    .pins    (cyPins),
    .done    (cyDone),
    .rdData  (cyRd)
  );

  always_comb begin
    st_d       = st_q;
    op_d       = op_q;
    addr_d     = addr_q;
    seq_d      = seq_q;
    byte_d     = byte_q;
    tmr_d      = tmr_q + 32'h1;
    last_d     = last_q;
    pollSeen_d = pollSeen_q;
    prev_d     = prev_q;
    rdv_d      = 1'b0;
    done_d     = 1'b0;
    tmo_d      = 1'b0;
    rdd_d      = rdd_q;
    lastByte_d = lastByte_q;
    cyStart    = 1'b0;
    cyWrite    = 1'b0;
    cyWord     = '{addr: addr_q, data: 8'h00};
    case (st_q)
      S_POWER: begin
        // [RULE_15] power-up wait
        if (tmr_q >= 32'(POWER_CYC - 1))
          st_d = S_IDLE;
      end
      S_IDLE: begin
        tmr_d = 32'h0;
        // [RULE_26] accept only when idle
        if (opValid) begin
          op_d   = opCode;
          addr_d = opAddr;
          seq_d  = 3'h0;
          byte_d = 9'h000;
          if (opCode == OP_READ) begin
            st_d = S_READ;
          end else begin
            st_d = S_CMD;
          end
        end
      end
      S_CMD: begin
        // [RULE_06] [RULE_19] [RULE_21] command writes
        cyWrite = 1'b1;
        cyWord  = seqWord;
        cyStart = (tmr_q == 32'h0);
        if (cyDone) begin
          tmr_d = 32'h0;
          seq_d = seq_q + 3'h1;
          // [RULE_25] sequence length from outside
          if (seq_q + 3'h1 >= seqLen || seq_q == 3'(SEQ_MAX - 1)) begin
            if (op_q == OP_SECTOR) begin
              st_d = S_LOAD;
            end else if (op_q == OP_ID_IN || op_q == OP_ID_OUT) begin
              done_d = 1'b1;
              st_d   = S_IDLE;
            end else begin
              st_d = S_GAP;
            end
          end
        end
      end
      S_LOAD: begin
        // [RULE_03] [RULE_09] [RULE_11] [RULE_12] whole sector loads
        cyWrite = 1'b1;
        cyWord  = '{addr: {addr_q[18:8], byte_q[7:0]}, data: loadData};
        cyStart = (tmr_q == 32'h0);
        if (cyDone) begin
          tmr_d      = 32'h0;
          lastByte_d = loadData;
          last_d     = byte_q[7:0];
          byte_d     = byte_q + 9'h001;
          // [RULE_04] all bytes loaded
          if (byte_q == 9'(SECTOR_BYTES - 1))
            st_d = S_GAP;
        end
      end
      S_GAP: begin
        // [RULE_10] let the load window close
        if (tmr_q >= 32'(GAP_CYC)) begin
          tmr_d      = 32'h0;
          pollSeen_d = 1'b0;
          prev_d     = 1'b0;
          st_d       = S_POLL;
        end
      end
      S_POLL: begin
        // [RULE_16] [RULE_17] poll the last loaded byte
        cyWord  = '{addr: {addr_q[18:8], last_q}, data: 8'h00};
        cyStart = !pollSeen_q;
        if (cyStart)
          pollSeen_d = 1'b1;
        if (cyDone) begin
          pollSeen_d = 1'b0;
          rdd_d      = cyRd;
          prev_d     = 1'b1;
          if (prev_q && (op_q != OP_SECTOR ||
               cyRd[POLL_BIT] == lastByte_q[POLL_BIT]) &&
              cyRd[TOGGLE_BIT] == rdd_q[TOGGLE_BIT]) begin
            done_d = 1'b1;
            st_d   = S_IDLE;
          end else if (tmr_q >= 32'(PROG_CYC)) begin
            // [RULE_18] time limit, checked between polls
            tmo_d  = 1'b1;
            done_d = 1'b1;
            st_d   = S_IDLE;
          end
        end
      end
      S_READ: begin
        // [RULE_01] [RULE_23] plain or id-mode read
        cyWord  = '{addr: addr_q, data: 8'h00};
        cyStart = (tmr_q == 32'h0);
        if (cyDone) begin
          rdd_d = cyRd;
          rdv_d = 1'b1;
          st_d  = S_IDLE;
        end
      end
      default: st_d = S_IDLE;
    endcase
    rdy_d = (st_d == S_IDLE);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q       <= S_POWER;
      op_q       <= OP_READ;
      addr_q     <= '0;
      seq_q      <= 3'h0;
      byte_q     <= 9'h000;
      tmr_q      <= 32'h0;
      last_q     <= 8'h00;
      pollSeen_q <= 1'b0;
      rdv_q      <= 1'b0;
      done_q     <= 1'b0;
      tmo_q      <= 1'b0;
      rdd_q      <= 8'h00;
      lastByte_q <= 8'h00;
      rdy_q      <= 1'b0;
      prev_q     <= 1'b0;
    end else begin
      st_q       <= st_d;
      op_q       <= op_d;
      addr_q     <= addr_d;
      seq_q      <= seq_d;
      byte_q     <= byte_d;
      tmr_q      <= tmr_d;
      last_q     <= last_d;
      pollSeen_q <= pollSeen_d;
      rdv_q      <= rdv_d;
      done_q     <= done_d;
      tmo_q      <= tmo_d;
      rdd_q      <= rdd_d;
      lastByte_q <= lastByte_d;
      rdy_q      <= rdy_d;
      prev_q     <= prev_d;
    end
  end

  assign opReady       = rdy_q;
  assign seqIndex      = seq_q;
  assign loadIndex     = byte_q[7:0];
  assign rdValid       = rdv_q;
  assign rdData        = rdd_q;
  assign opDone        = done_q;
  assign opTimeout     = tmo_q;
  // [RULE_02] [RULE_13] pins straight from cycle flops
  assign flashCeN      = cyPins.ceN;
  assign flashOeN      = cyPins.oeN;
  assign flashWeN      = cyPins.weN;
  assign address_lines = cyPins.addr;
  assign flashDataOut  = cyPins.dout;
  assign flashDataOe   = cyPins.doutEn;
endmodule : sector_flash_host

// file: verification/sector_flash_host_assertions.sv
// checker: pin-level properties of the sector flash host controller
`timescale 1ns/10ps
module sector_flash_host_assertions #(
  parameter int POWER_CYC = flash_host_pkg::POWER_UP_CYC,
  parameter int GAP_CYC   = flash_host_pkg::LOAD_GAP_CYC
) (
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic        opReady,
  input wire logic        rdValid,
  input wire logic        opDone,
  input wire logic        opTimeout,
  input wire logic        flashCeN,
  input wire logic        flashOeN,
  input wire logic        flashWeN,
  input wire logic [18:0] address_lines,
  input wire logic [7:0]  flashDataOut,
  input wire logic        flashDataOe
);
  import flash_host_pkg::*;
  int   pwrCnt_q, pwrCnt_d, gapCnt_q, gapCnt_d;
  logic armed_q, armed_d;
  // cycles since reset, cycles since the write strobe rose
  always_comb begin
    pwrCnt_d = (pwrCnt_q < POWER_CYC) ? pwrCnt_q + 1 : pwrCnt_q;
    gapCnt_d = flashWeN ? gapCnt_q + 1 : 0;
    armed_d  = opReady ? 1'b0 : (!flashWeN ? 1'b1 : armed_q);
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pwrCnt_q <= 0;
      gapCnt_q <= 0;
      armed_q  <= 1'b0;
    end else begin
      pwrCnt_q <= pwrCnt_d;
      gapCnt_q <= gapCnt_d;
      armed_q  <= armed_d;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  AST_READ_PINS: assert property (
    !flashOeN |-> !flashCeN && flashWeN && !flashDataOe)
    else $error("read strobe with wrong pins");
  AST_LOAD_PINS: assert property (
    !flashWeN |-> !flashCeN && flashOeN && flashDataOe)
    else $error("write strobe with wrong pins");
  AST_WE_WIDTH: assert property (
    $fell(flashWeN) |-> !flashWeN [*4])
    else $error("write strobe too short");
  AST_ADDR_HOLD: assert property (
    !flashWeN && $past(!flashWeN) |->
      $stable(address_lines) && $stable(flashDataOut))
    else $error("address or data moved in strobe");
  AST_POWER_WAIT: assert property (
    pwrCnt_q < POWER_CYC - 1 |-> flashWeN && !opReady)
    else $error("access during power wait");
  AST_LOAD_GAP: assert property (
    $fell(flashWeN) && armed_q |-> gapCnt_q < GAP_CYC)
    else $error("load gap too long");
  AST_IDLE_PINS: assert property (
    opReady |-> flashCeN && flashWeN && flashOeN)
    else $error("strobe while idle");
  AST_TIMEOUT_DONE: assert property (
    opTimeout |-> opDone)
    else $error("timeout without done");
  AST_RD_PULSE: assert property (
    rdValid |=> !rdValid)
    else $error("read valid longer than a cycle");
  cover property (opDone && !opTimeout);
  cover property (opTimeout);
  cover property (rdValid);
endmodule : sector_flash_host_assertions

bind sector_flash_host sector_flash_host_assertions #(
  .POWER_CYC(POWER_CYC), .GAP_CYC(GAP_CYC)) u_chk (
  .clk(clk), .arst_n(arst_n), .opReady(opReady), .rdValid(rdValid),
  .opDone(opDone), .opTimeout(opTimeout), .flashCeN(flashCeN),
  .flashOeN(flashOeN), .flashWeN(flashWeN),
  .address_lines(address_lines), .flashDataOut(flashDataOut),
  .flashDataOe(flashDataOe));

// file: verification/flash_device_model.sv
// device model: byte-wide sector flash behind the host pins
`timescale 1ns/10ps
module flash_device_model #(
  parameter int GAP  = 10,
  parameter int BUSY = 60,
  parameter int PWR  = 20
) (
  input  wire logic        clk,
  input  wire logic        ceN,
  input  wire logic        oeN,
  input  wire logic        weN,
  input  wire logic [18:0] addr,
  input  wire logic [7:0]  hostData,
  input  wire logic        hostOe,
  input  wire logic        slow,
  output logic      [7:0]  bus
);
  import flash_host_pkg::*;
  logic [7:0] mem [int];
  cmd_word_t  wq [$];
  logic [7:0] last = 8'h00;
  logic       blank = 1'b0, lockLo = 1'b0, idMode = 1'b0, tog = 1'b0;
  int         gap = 0, busy = 0, up = 0;
  logic       ldLow = 1'b0;
  int         lowCnt = 0;
  cmd_word_t  ldWord = '0;
  initial bus = 8'h00;
  function automatic cmd_word_t cmd(int k, int i);
    return {19'h05555 ^ 19'(i * 3), 8'(8'ha0 + k * 8 + i)};
  endfunction : cmd
  function automatic bit seq(int k, int n);
    if (wq.size() < n) return 1'b0;
    for (int i = 0; i < n; i++) if (wq[i] !== cmd(k, i)) return 1'b0;
    return 1'b1;
  endfunction : seq
  function automatic logic [7:0] rd(logic [18:0] a);
    if (idMode && a == LOCK_LO_ADDR) return lockLo ? LOCK_SET : LOCK_FREE;
    if (idMode && a == LOCK_HI_ADDR) return LOCK_FREE;
    if (mem.exists(a)) return mem[a];
    return blank ? 8'hff : a[7:0] ^ a[15:8];
  endfunction : rd
  always @(negedge clk) begin
    bus <= hostOe ? hostData : (!ceN && !oeN && weN) ?
      ((busy > 0) ? {~last[7], tog, last[5:0]} : rd(addr)) : ~bus;
  end
  always @(posedge oeN) tog <= ~tog;
  // load window closes after the gap
  always @(posedge clk) begin
    if (up < PWR) up++;
    if (busy > 0) busy--;
    if (ldLow && weN && lowCnt * CLK_PERIOD_NS >= STROBE_MIN_NS &&
        up >= PWR && busy == 0) begin
      wq.push_back(ldWord);
      last = ldWord.data;
      gap = 0;
      if (seq(4, 3)) begin
        idMode = 1'b1;
        wq.delete();
      end
      if (seq(5, 3)) begin
        idMode = 1'b0;
        wq.delete();
      end
    end
    // strobes as they stood before this edge's updates land
    ldLow  = !ceN && !weN && oeN;
    lowCnt = ldLow ? lowCnt + 1 : 0;
    if (ldLow) ldWord = {addr, hostData};
    if (wq.size() > 0 && weN) gap++;
    if (gap >= GAP && wq.size() > 0) begin
      gap = 0;
      // slow mode overruns the program time
      busy = slow ? 400 : BUSY;
      if (seq(1, 3) && wq.size() > 3 &&
          !(lockLo && wq[3].addr < BOOT_BLOCK_BYTES)) begin
        for (int i = 0; i < 256; i++) mem[{wq[3].addr[18:8], 8'(i)}] = 8'hff;
        for (int i = 3; i < wq.size(); i++) mem[wq[i].addr] = wq[i].data;
      end
      // chip erase unless a block is locked
      else if (seq(2, 6) && !lockLo) begin
        mem.delete();
        blank = 1'b1;
      end
      // lower block lockout, else timer only
      else if (seq(3, 7)) lockLo = 1'b1;
      wq.delete();
    end
  end
endmodule : flash_device_model

// file: verification/sector_flash_host_bench.sv
// testbench: host controller against the behavioural flash model
`timescale 1ns/10ps
module sector_flash_host_bench;
  import flash_host_pkg::*;
  logic        clk = 1'b0, arst_n = 1'b0, opValid = 1'b0;
  logic        slow = 1'b0, bad = 1'b0;
  op_t         opCode = OP_READ;
  logic [18:0] opAddr = 19'h0, address_lines;
  logic [2:0]  seqLen = 3'h3, seqIndex;
  logic [7:0]  loadData, flashDataIn, loadIndex, rdData, flashDataOut, e;
  logic        opReady, rdValid, opDone, opTimeout, flashDataOe;
  logic        flashCeN, flashOeN, flashWeN;
  cmd_word_t   seqWord;
  logic [7:0]  page [256];
  logic [31:0] seed = 32'h86cde3f4;
  logic [10:0] s;
  int          badCount = 0, nTests = 0;
  always #12.5 clk = ~clk;
  assign seqWord  = u_dev.cmd(int'(opCode), int'(seqIndex)) ^ 27'(bad);
  assign loadData = page[loadIndex];
  sector_flash_host #(.POWER_CYC(20), .PROG_CYC(200), .GAP_CYC(10)) u_dut (
    .clk(clk), .arst_n(arst_n), .opValid(opValid), .opCode(opCode),
    .opAddr(opAddr), .seqLen(seqLen), .seqWord(seqWord),
    .loadData(loadData), .flashDataIn(flashDataIn), .opReady(opReady),
    .seqIndex(seqIndex), .loadIndex(loadIndex), .rdValid(rdValid),
    .rdData(rdData), .opDone(opDone), .opTimeout(opTimeout),
    .flashCeN(flashCeN), .flashOeN(flashOeN), .flashWeN(flashWeN),
    .address_lines(address_lines), .flashDataOut(flashDataOut),
    .flashDataOe(flashDataOe));
  flash_device_model u_dev (
    .clk(clk), .ceN(flashCeN), .oeN(flashOeN), .weN(flashWeN),
    .addr(address_lines), .hostData(flashDataOut), .hostOe(flashDataOe),
    .slow(slow), .bus(flashDataIn));
  function automatic logic [31:0] lfsr(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr
  function automatic logic [7:0] pat(logic [18:0] a);
    return a[7:0] ^ a[15:8];
  endfunction : pat
  task automatic check(string nm, logic [7:0] got, logic [7:0] exp);
    nTests++;
    if (got !== exp) begin
      badCount++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : check
  task automatic printVerdict();
    $display("checks %0d mismatches %0d", nTests, badCount);
    if (badCount == 0 && nTests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : printVerdict
  task automatic run(op_t c, logic [18:0] a);
    int n;
    n = 0;
    while (opReady !== 1'b1) begin
      @(posedge clk);
      #2;
    end
    opCode  = c;
    opAddr  = a;
    seqLen  = c == OP_CHIP ? 3'h6 : c == OP_LOCK ? 3'h7 : 3'h3;
    opValid = 1'b1;
    @(posedge clk);
    #2 opValid = 1'b0;
    while (rdValid !== 1'b1 && opDone !== 1'b1 && n < 20000) begin
      @(posedge clk);
      #2 n++;
    end
    if (n >= 20000) begin
      badCount++;
      printVerdict();
    end
  endtask : run
  task automatic rd(logic [18:0] a, logic [7:0] x, string nm);
    run(OP_READ, a);
    check(nm, rdData, x);
  endtask : rd
  task automatic prog(logic [10:0] sec);
    for (int i = 0; i < 256; i++) begin
      seed = lfsr(seed);
      page[i] = seed[7:0];
    end
    run(OP_SECTOR, {sec, 8'h00});
  endtask : prog
  initial begin
    #1000000;
    badCount++;
    printVerdict();
  end
  initial begin
    repeat (4) @(posedge clk);
    #2 arst_n = 1'b1;
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      rd(seed[18:0], pat(seed[18:0]), "read");
    end
    s = {3'h1, seed[7:0]};
    prog(s);
    check("timeout", {7'h0, opTimeout}, 8'h00);
    rd({s, 8'h00}, page[0], "first byte");
    rd({s, 8'hff}, page[255], "last byte");
    rd({s, 8'h7e}, page[126], "mid byte");
    e = page[5];
    bad = 1'b1;
    prog(s);
    bad = 1'b0;
    rd({s, 8'h05}, e, "no unlock");
    run(OP_ID_IN, 19'h0);
    rd(LOCK_LO_ADDR, LOCK_FREE, "lock free");
    run(OP_ID_OUT, 19'h0);
    run(OP_CHIP, {s, 8'h00});
    rd({s, 8'h05}, 8'hff, "chip erased");
    prog(s);
    run(OP_LOCK, 19'h0);
    run(OP_ID_IN, 19'h0);
    rd(LOCK_LO_ADDR, LOCK_SET, "lock set");
    rd(LOCK_HI_ADDR, LOCK_FREE, "upper free");
    run(OP_ID_OUT, 19'h0);
    run(OP_CHIP, {s, 8'h00});
    rd({s, 8'h05}, page[5], "erase blocked");
    prog(11'h005);
    rd(19'h00505, 8'hff, "boot locked");
    slow = 1'b1;
    prog(s);
    check("timeout", {7'h0, opTimeout}, 8'h01);
    slow = 1'b0;
    printVerdict();
  end
endmodule : sector_flash_host_bench
